// file: logic/vme_host_bus_interface.sv
// host side bus bridge: polled transfers, mask, interrupts, mapping
`timescale 1ns/1ps
`include "vme_host_bus_interface_consts.svh"
module vme_host_bus_interface (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // host command
    input  wire logic        cmd_valid_i,
    output logic             cmd_ready_o,
    input  wire logic [3:0]  cmd_op_i,
    input  wire logic [31:0] cmd_addr_i,
    input  wire logic [31:0] cmd_data_i,
    input  wire logic [31:0] cmd_old_i,
    input  wire logic [31:0] cmd_len_i,
    input  wire logic [5:0]  cmd_am_i,
    input  wire logic        cmd_am_use_i,
    input  wire logic [1:0]  cmd_size_i,
    input  wire logic        cmd_size_use_i,
    input  wire logic [1:0]  cmd_off_i,
    input  wire logic        cmd_shuf_i,
    input  wire logic        cmd_shuf_use_i,
    // host answer
    output logic             rsp_valid_o,
    output logic [31:0]      rsp_data_o,
    output logic             rsp_err_o,
    output logic             rsp_ok_o,
    // received interrupts, same clock
    input  wire logic        int_seen_i,
    input  wire logic [2:0]  int_level_i,
    input  wire logic [7:0]  int_status_i,
    output logic             hnd_valid_o,
    output logic [7:0]       hnd_status_o,
    // bus master pins
    output logic             bus_own_o,
    output logic             as_o,
    output logic             wr_o,
    output logic [5:0]       am_o,
    output logic [31:0]      a_o,
    output logic [3:0]       lane_o,
    output logic [31:0]      d_o,
    output logic             d_oe_o,
    input  wire logic [31:0] d_i,
    input  wire logic        dtack_n_i,
    input  wire logic        berr_n_i,
    // interrupter pins
    output logic [7:1]       irq_oe_o,
    input  wire logic        iack_n_i,
    output logic [7:0]       stat_o,
    output logic             stat_oe_o
);
    typedef vme_host_bus_interface_pkg::op_type op_type;
    typedef vme_host_bus_interface_pkg::bus_state_type bus_state_type;

    bus_state_type st_r;           // bus sequencer
    logic [6:0]  mask_r;           // level enables, bit 0 is level 1
    logic        pend_err_r;       // write error waiting for a read
    logic [3:0]  op_r;             // operation in flight
    logic        cas_wr_r;         // second half of compare-and-store
    logic        err_r;            // error of current cycle
    logic [31:0] rdat_r;           // captured read data
    logic [10:0] tmo_r;            // timeout counter
    logic [2:0]  plev_r;           // level being posted
    logic [7:0]  pstat_r;          // status byte being posted
    // bus mode context
    logic        ctx_r;
    logic [5:0]  m_am_r;
    logic [1:0]  m_size_r;
    logic        m_shuf_r;
    logic        win_r;
    logic [31:0] win_lo_r;
    logic [31:0] win_hi_r;
    logic        shuf_r;
    // synchronisers
    logic [31:0] d_m_r, d_s_r;
    logic [2:0]  pin_m_r, pin_s_r;
    logic        dtack_s, berr_s, iack_s;
    // effective options and helpers
    logic [5:0]  e_am;
    logic [1:0]  e_size;
    logic        e_shuf;
    logic [3:0]  e_lane;
    logic [32:0] m_end;
    logic        conflict;
    logic        tmo_hit;
    logic [31:0] rd_fix;
    logic        idle_go;
    op_type      op;

    assign op = op_type'(cmd_op_i);
    assign cmd_ready_o = (st_r == vme_host_bus_interface_pkg::B_IDLE);
    assign idle_go = cmd_valid_i & cmd_ready_o;
    assign bus_own_o = (st_r != vme_host_bus_interface_pkg::B_IDLE);

    // two flops on every pin input; only the second stage is read
    always_ff @(posedge ref_clk_i)
    begin
        d_m_r   <= d_i;
        d_s_r   <= d_m_r;
        pin_m_r <= {~iack_n_i, ~berr_n_i, ~dtack_n_i};
        pin_s_r <= pin_m_r;
    end
    assign dtack_s = pin_s_r[0];
    assign berr_s  = pin_s_r[1];
    assign iack_s  = pin_s_r[2];

    // explicit option wins, otherwise the ambient mode
    assign e_am   = cmd_am_use_i   ? cmd_am_i   : m_am_r;
    assign e_size = cmd_size_use_i ? cmd_size_i : m_size_r;
    assign e_shuf = cmd_shuf_use_i ? cmd_shuf_i : m_shuf_r;

    // byte lanes from size and offset
    always_comb
    begin
        unique case (e_size)
            `SIZE_BYTE: e_lane = 4'h1 << cmd_off_i;
            `SIZE_HALF: e_lane = cmd_off_i[1] ? 4'hc : 4'h3;
            default:    e_lane = 4'hf;
        endcase
    end

    // byte reversal on read data when shuffling is asked for
    assign rd_fix = shuf_r ? {d_s_r[7:0], d_s_r[15:8], d_s_r[23:16],
                              d_s_r[31:24]} : d_s_r;

    // map checks: window end, conflicts with the context
    assign m_end = {1'b0, cmd_addr_i} + {1'b0, cmd_len_i};
    assign conflict = (cmd_am_use_i & (cmd_am_i != m_am_r))
                    | (cmd_size_use_i & (cmd_size_i != m_size_r));
    assign tmo_hit = (tmo_r == 11'(`BUS_TMO_CYC - 1));

    // interrupt enable mask
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            mask_r <= `MASK_RST;
        else if (idle_go)
        begin
            unique case (op)
                vme_host_bus_interface_pkg::OP_MASKAND:
                    mask_r <= mask_r & cmd_data_i[6:0];
                vme_host_bus_interface_pkg::OP_MASKOR:
                    mask_r <= mask_r | cmd_data_i[6:0];
                vme_host_bus_interface_pkg::OP_ENABLE:
                    if (cmd_data_i[2:0] != 3'h0)
                        mask_r[cmd_data_i[2:0] - 3'h1] <= 1'b1;
                vme_host_bus_interface_pkg::OP_DISABLE:
                    if (cmd_data_i[2:0] != 3'h0)
                        mask_r[cmd_data_i[2:0] - 3'h1] <= 1'b0;
                default: ;
            endcase
        end
    end

    // received interrupt dispatch, gated by its level's enable
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            hnd_valid_o  <= 1'b0;
            hnd_status_o <= 8'h00;
        end
        else
        begin
            hnd_valid_o <= int_seen_i & (int_level_i != 3'h0)
                         & mask_r[int_level_i - 3'h1];
            if (int_seen_i)
                hnd_status_o <= int_status_i;
        end
    end

    // bus-mode context and address window; held until mode off
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            ctx_r    <= 1'b0;
            m_am_r   <= `AM_RST;
            m_size_r <= `SIZE_RST;
            m_shuf_r <= 1'b0;
            win_r    <= 1'b0;
            win_lo_r <= 32'h00000000;
            win_hi_r <= 32'h00000000;
        end
        else if (idle_go)
        begin
            if (op == vme_host_bus_interface_pkg::OP_MODEON && !ctx_r)
            begin
                ctx_r    <= 1'b1;
                m_am_r   <= cmd_am_i;
                m_size_r <= cmd_size_i;
                m_shuf_r <= cmd_shuf_i;
            end
            if (op == vme_host_bus_interface_pkg::OP_MODEOFF)
            begin
                ctx_r <= 1'b0;
                win_r <= 1'b0;
            end
            if (op == vme_host_bus_interface_pkg::OP_MAP && ctx_r
                && !win_r && !conflict && !m_end[32]
                && cmd_len_i != 32'h0)
            begin
                win_r    <= 1'b1;
                win_lo_r <= cmd_addr_i;
                win_hi_r <= m_end[31:0];
            end
        end
    end

    // bus sequencer: polled cycles, compare-and-store, posting
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            st_r     <= vme_host_bus_interface_pkg::B_IDLE;
            op_r     <= 4'h0;
            cas_wr_r <= 1'b0;
            err_r    <= 1'b0;
            tmo_r    <= 11'h000;
            as_o     <= 1'b0;
            wr_o     <= 1'b0;
            am_o     <= `AM_RST;
            a_o      <= 32'h00000000;
            lane_o   <= 4'h0;
            d_o      <= 32'h00000000;
            d_oe_o   <= 1'b0;
            shuf_r   <= 1'b0;
            rdat_r   <= 32'h00000000;
            plev_r   <= 3'h0;
            pstat_r  <= 8'h00;
        end
        else
        begin
            unique case (st_r)
                vme_host_bus_interface_pkg::B_IDLE:
                    if (idle_go)
                    begin
                        op_r     <= cmd_op_i;
                        cas_wr_r <= 1'b0;
                        err_r    <= 1'b0;
                        tmo_r    <= 11'h000;
                        am_o     <= e_am;
                        a_o      <= cmd_addr_i;
                        lane_o   <= e_lane;
                        shuf_r   <= e_shuf;
                        d_o      <= cmd_data_i;
                        plev_r   <= cmd_addr_i[2:0];
                        pstat_r  <= cmd_data_i[7:0];
                        if (op == vme_host_bus_interface_pkg::OP_READ
                            || op == vme_host_bus_interface_pkg::OP_WRITE
                            || op == vme_host_bus_interface_pkg::OP_CAS)
                        begin
                            wr_o <= (op == vme_host_bus_interface_pkg::
                                     OP_WRITE);
                            st_r <= vme_host_bus_interface_pkg::B_STRB;
                        end
                        else if (op == vme_host_bus_interface_pkg::OP_POST
                                 && cmd_addr_i[2:0] != 3'h0)
                            st_r <= vme_host_bus_interface_pkg::B_POST;
                    end
                vme_host_bus_interface_pkg::B_STRB:
                begin
                    as_o   <= 1'b1;
                    d_oe_o <= wr_o;
                    st_r   <= vme_host_bus_interface_pkg::B_WAIT;
                end
                vme_host_bus_interface_pkg::B_WAIT:
                begin
                    tmo_r <= tmo_r + 11'h001;
                    if (berr_s || tmo_hit || dtack_s)
                    begin
                        err_r  <= berr_s | (tmo_hit & ~dtack_s);
                        rdat_r <= rd_fix;
                        as_o   <= 1'b0;
                        d_oe_o <= 1'b0;
                        tmo_r  <= 11'h000;
                        st_r   <= vme_host_bus_interface_pkg::B_REL;
                    end
                end
                vme_host_bus_interface_pkg::B_REL:
                begin
                    tmo_r <= tmo_r + 11'h001;
                    if (!dtack_s && !berr_s || tmo_hit)
                    begin
                        // bus stays owned between the two halves
                        if (op_r == vme_host_bus_interface_pkg::OP_CAS
                            && !cas_wr_r && !err_r && rdat_r == cmd_old_i)
                        begin
                            cas_wr_r <= 1'b1;
                            wr_o     <= 1'b1;
                            tmo_r    <= 11'h000;
                            st_r     <= vme_host_bus_interface_pkg::B_STRB;
                        end
                        else
                            st_r <= vme_host_bus_interface_pkg::B_IDLE;
                    end
                end
                vme_host_bus_interface_pkg::B_POST:
                    if (iack_s)
                        st_r <= vme_host_bus_interface_pkg::B_PACK;
                vme_host_bus_interface_pkg::B_PACK:
                    if (!iack_s)
                        st_r <= vme_host_bus_interface_pkg::B_IDLE;
                default:
                    st_r <= vme_host_bus_interface_pkg::B_IDLE;
            endcase
        end
    end

    // interrupter drive: request until acknowledge, then status
    assign irq_oe_o  = (st_r == vme_host_bus_interface_pkg::B_POST)
                     ? (7'h01 << (plev_r - 3'h1)) : 7'h00;
    assign stat_oe_o = (st_r == vme_host_bus_interface_pkg::B_PACK);
    assign stat_o    = pstat_r;

    // answers; a write error waits in pend_err_r for the next read
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            rsp_valid_o <= 1'b0;
            rsp_data_o  <= 32'h00000000;
            rsp_err_o   <= 1'b0;
            rsp_ok_o    <= 1'b0;
            pend_err_r  <= 1'b0;
        end
        else
        begin
            rsp_valid_o <= 1'b0;
            if (st_r == vme_host_bus_interface_pkg::B_REL
                && (!dtack_s && !berr_s || tmo_hit)
                && !(op_r == vme_host_bus_interface_pkg::OP_CAS
                     && !cas_wr_r && !err_r && rdat_r == cmd_old_i))
            begin
                rsp_valid_o <= 1'b1;
                rsp_data_o  <= rdat_r;
                rsp_ok_o    <= cas_wr_r & ~err_r;
                if (op_r == vme_host_bus_interface_pkg::OP_WRITE
                    || cas_wr_r)
                begin
                    rsp_err_o  <= 1'b0;
                    pend_err_r <= pend_err_r | err_r;
                end
                else
                begin
                    rsp_err_o  <= err_r | pend_err_r;
                    pend_err_r <= 1'b0;
                end
            end
            else if (st_r == vme_host_bus_interface_pkg::B_PACK
                     && !iack_s)
            begin
                rsp_valid_o <= 1'b1;
                rsp_err_o   <= 1'b0;
                rsp_ok_o    <= 1'b1;
            end
            else if (idle_go
                     && op != vme_host_bus_interface_pkg::OP_READ
                     && op != vme_host_bus_interface_pkg::OP_WRITE
                     && op != vme_host_bus_interface_pkg::OP_CAS
                     && !(op == vme_host_bus_interface_pkg::OP_POST
                          && cmd_addr_i[2:0] != 3'h0))
            begin
                rsp_valid_o <= 1'b1;
                rsp_ok_o    <= 1'b1;
                rsp_err_o   <= 1'b0;
                rsp_data_o  <= 32'h00000000;
                unique case (op)
                    vme_host_bus_interface_pkg::OP_MASKAND:
                        rsp_data_o <= {25'h0, mask_r & cmd_data_i[6:0]};
                    vme_host_bus_interface_pkg::OP_MASKOR:
                        rsp_data_o <= {25'h0, mask_r | cmd_data_i[6:0]};
                    vme_host_bus_interface_pkg::OP_MODEON:
                        rsp_err_o <= ctx_r;
                    vme_host_bus_interface_pkg::OP_MAP:
                    begin
                        if (!ctx_r || conflict || m_end[32]
                            || cmd_len_i == 32'h0)
                            rsp_err_o <= 1'b1;
                        else if (win_r && (cmd_addr_i < win_lo_r
                                 || m_end[31:0] > win_hi_r))
                            rsp_err_o <= 1'b1;
                        rsp_data_o <= `PHYS_BASE + (cmd_addr_i
                                    - (win_r ? win_lo_r : cmd_addr_i));
                    end
                    vme_host_bus_interface_pkg::OP_POST:
                        rsp_err_o <= 1'b1;
                    default: ;
                endcase
            end
        end
    end

    // checks
    sequence cas_miss_s;
        st_r == vme_host_bus_interface_pkg::B_REL && !cas_wr_r
        && op_r == vme_host_bus_interface_pkg::OP_CAS && rsp_valid_o == 0
        && rdat_r != cmd_old_i;
    endsequence
    sequence and_op_s;
        idle_go && op == vme_host_bus_interface_pkg::OP_MASKAND;
    endsequence
    mask_and_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        and_op_s |=> mask_r == ($past(mask_r) & $past(cmd_data_i[6:0])))
        else $error("mask and wrong");
    mask_or_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        idle_go && op == vme_host_bus_interface_pkg::OP_MASKOR |=>
        rsp_data_o[6:0] == mask_r) else $error("mask or wrong");
    cas_nowrite_a: assert property (@(posedge ref_clk_i)
        disable iff (rst_i) cas_miss_s ##1 !bus_own_o |-> !cas_wr_r)
        else $error("store on miss");
    write_noerr_a: assert property (@(posedge ref_clk_i)
        disable iff (rst_i) rsp_valid_o && $past(op_r) ==
        vme_host_bus_interface_pkg::OP_WRITE && $past(st_r) ==
        vme_host_bus_interface_pkg::B_REL |-> !rsp_err_o)
        else $error("write reported error");
    berr_err_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        st_r == vme_host_bus_interface_pkg::B_WAIT && berr_s |=> err_r)
        else $error("bus error lost");
    post_wait_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        stat_oe_o |-> $past(iack_s) || $past(stat_oe_o))
        else $error("status before ack");
    hnd_gate_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        hnd_valid_o |-> $past(int_level_i) != 3'h0
        && $past(mask_r[int_level_i - 3'h1]))
        else $error("disabled level dispatched");
    ctx_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ctx_r && $past(ctx_r) |-> $stable(m_am_r) && $stable(m_size_r))
        else $error("context changed");
    cas_own_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        st_r == vme_host_bus_interface_pkg::B_STRB && cas_wr_r
        |-> $past(bus_own_o)) else $error("bus released");
endmodule : vme_host_bus_interface

// file: logic/vme_host_bus_interface_consts.svh
// constants for the bus interface: timing, encodings and resets
`ifndef VME_HOST_BUS_INTERFACE_CONSTS_SVH
`define VME_HOST_BUS_INTERFACE_CONSTS_SVH
`define CLK_MHZ          20
`define BUS_TMO_US       64
`define BUS_TMO_CYC      (`BUS_TMO_US * `CLK_MHZ)
`define MASK_RST         7'h00
`define AM_RST           6'h0d
`define SIZE_RST         2'h2
`define SIZE_BYTE        2'h0
`define SIZE_HALF        2'h1
`define PHYS_BASE        32'hc0000000
`endif

// file: logic/vme_host_bus_interface_pkg.sv
// types for the bus interface
package vme_host_bus_interface_pkg;
    typedef enum logic [3:0] {
        OP_READ    = 4'h0,
        OP_WRITE   = 4'h1,
        OP_CAS     = 4'h2,
        OP_MASKAND = 4'h3,
        OP_MASKOR  = 4'h4,
        OP_ENABLE  = 4'h5,
        OP_DISABLE = 4'h6,
        OP_POST    = 4'h7,
        OP_MAP     = 4'h8,
        OP_MODEON  = 4'h9,
        OP_MODEOFF = 4'ha
    } op_type;
    typedef enum logic [2:0] {
        B_IDLE = 3'h0,
        B_STRB = 3'h1,
        B_WAIT = 3'h2,
        B_REL  = 3'h3,
        B_POST = 3'h4,
        B_PACK = 3'h5
    } bus_state_type;
endpackage : vme_host_bus_interface_pkg

// file: testbench/vme_bus_partner.sv
// bus partner: word slave with error and silent holes, irq handler
`timescale 1ns/1ps
module vme_bus_partner (
    // bus master side
    input  wire logic        ref_clk_i,
    input  wire logic        as_i,
    input  wire logic        wr_i,
    input  wire logic [31:0] a_i,
    input  wire logic [31:0] wd_i,
    input  wire logic        oe_i,
    output logic [31:0]      rd_o,
    output logic             dtack_n_o,
    output logic             berr_n_o,
    // interrupt handler side
    input  wire logic [7:1]  irq_i,
    input  wire logic [7:0]  stat_i,
    input  wire logic        stat_oe_i,
    output logic             iack_n_o,
    output logic [7:1]       lvl_o,
    output logic [7:0]       got_o
);
    logic [31:0] mem [0:15]; // small word store
    int          cnt;        // strobe age, sets response delay
    initial
    begin
        rd_o = 32'h0;
        dtack_n_o = 1'h1;
        berr_n_o = 1'h1;
        iack_n_o = 1'h1;
    end
    // slave: bit 4 of address makes it slow, bit 30 silent, bit 31 berr
    always @(posedge ref_clk_i)
    begin
        if (!as_i)
        begin
            cnt <= 0;
            dtack_n_o <= 1'h1;
            berr_n_o <= 1'h1;
            rd_o <= ~rd_o; // released lines toggle every cycle instead of holding old data
        end
        else if (cnt < 1 + 5 * a_i[4])
            cnt <= cnt + 1;
        else if (a_i[31])
            berr_n_o <= 1'h0;
        else if (!a_i[30])
        begin
            dtack_n_o <= 1'h0;
            if (wr_i && oe_i)
                mem[a_i[5:2]] <= wd_i;
            else if (!wr_i)
                rd_o <= mem[a_i[5:2]];
        end
    end
    // handler: acknowledge a request, take the status byte, release
    always @(posedge ref_clk_i)
    begin
        if (irq_i != 7'h00 && iack_n_o)
        begin
            iack_n_o <= 1'h0;
            lvl_o <= irq_i;
        end
        else if (!iack_n_o && stat_oe_i)
        begin
            iack_n_o <= 1'h1;
            got_o <= stat_i;
        end
    end
endmodule : vme_bus_partner

// file: testbench/vme_host_bus_interface_tb.sv
// self-checking bench for the host bus bridge
`timescale 1ns/1ps
module vme_host_bus_interface_tb;
    logic        ref_clk, rst, cmd_valid, cmd_am_use, int_seen; // drives
    logic [3:0]  cmd_op;
    logic [31:0] cmd_addr, cmd_data, cmd_aux, rsp_data, a, d_o, rd;
    logic [5:0]  cmd_am, am;
    logic [2:0]  int_level;
    logic [7:0]  int_status, hnd_status, stat, got;
    logic [7:1]  irq_oe, lvl;
    logic        cmd_ready, rsp_valid, rsp_err, rsp_ok, hnd_valid, as, wr;
    logic        d_oe, dtack_n, berr_n, iack_n, stat_oe, r_err, r_ok;
    logic        own, shuf; // bus ownership seen, shuffle option driven
    logic [3:0]  lane;      // byte lanes of the last cycle
    logic [31:0] r_data; // captured answer
    int          fails, cmp_count;
    vme_host_bus_interface i_vme_host_bus_interface (.ref_clk_i(ref_clk),
        .rst_i(rst), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
        .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data),
        .cmd_old_i(cmd_aux), .cmd_len_i(cmd_aux), .cmd_am_i(cmd_am),
        .cmd_am_use_i(cmd_am_use), .cmd_size_i(2'h2), .cmd_size_use_i(1'h0),
        .cmd_off_i(2'h0), .cmd_shuf_i(shuf), .cmd_shuf_use_i(shuf),
        .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_err_o(rsp_err),
        .rsp_ok_o(rsp_ok), .int_seen_i(int_seen), .int_level_i(int_level),
        .int_status_i(int_status), .hnd_valid_o(hnd_valid),
        .hnd_status_o(hnd_status), .bus_own_o(own), .as_o(as), .wr_o(wr),
        .am_o(am), .a_o(a), .lane_o(lane), .d_o(d_o), .d_oe_o(d_oe), .d_i(rd),
        .dtack_n_i(dtack_n), .berr_n_i(berr_n), .irq_oe_o(irq_oe),
        .iack_n_i(iack_n), .stat_o(stat), .stat_oe_o(stat_oe));
    vme_bus_partner i_vme_bus_partner (.ref_clk_i(ref_clk), .as_i(as),
        .wr_i(wr), .a_i(a), .wd_i(d_o), .rd_o(rd), .dtack_n_o(dtack_n),
        .oe_i(d_oe), .berr_n_o(berr_n), .irq_i(irq_oe), .stat_i(stat),
        .stat_oe_i(stat_oe), .iack_n_o(iack_n), .lvl_o(lvl), .got_o(got));
    // one comparison, counted
    task automatic chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk
    // one command: hold valid until taken, then wait for the answer;
    // outputs are looked at on the falling edge, where they are settled
    task automatic cmd(input logic [3:0] op, input logic [31:0] ad, da, ax);
        int n;
        @(posedge ref_clk);
        {cmd_valid, cmd_op, cmd_addr, cmd_data, cmd_aux} <= {1'h1,op,ad,da,ax};
        @(negedge ref_clk);
        for (n = 0; cmd_ready !== 1'h1 && n < 10; n++)
            @(negedge ref_clk);
        @(posedge ref_clk);
        cmd_valid <= 1'h0;
        @(negedge ref_clk);
        for (n = 0; rsp_valid !== 1'h1 && n < 4000; n++)
            @(negedge ref_clk);
        chk("answer", 1'h1, rsp_valid);
        r_data = rsp_data;
        r_err = rsp_err;
        r_ok = rsp_ok;
    endtask : cmd
    // received interrupt, handler call expected or not
    task automatic irq(input logic [2:0] l, input logic [7:0] s, input e);
        @(posedge ref_clk);
        {int_seen, int_level, int_status} <= {1'h1, l, s};
        @(posedge ref_clk);
        int_seen <= 1'h0;
        @(negedge ref_clk);
        chk("handler", e, hnd_valid);
        if (e)
            chk("status", s, hnd_status);
    endtask : irq
    // per-level enables, and/or updates, dispatch gated by mask
    task automatic mask_test;
        cmd(4'h5, 32'h0, 32'h1, 32'h0);
        cmd(4'h5, 32'h0, 32'h7, 32'h0);
        cmd(4'h3, 32'h0, 32'hffffffff, 32'h0);
        chk("and read", 32'h41, r_data);
        cmd(4'h6, 32'h0, 32'h1, 32'h0);
        cmd(4'h4, 32'h0, 32'h0, 32'h0);
        chk("or read", 32'h40, r_data);
        irq(3'h7, 8'h5a, 1'h1);
        irq(3'h1, 8'h33, 1'h0);
        cmd(4'h4, 32'h0, 32'h1, 32'h0);
        chk("or set", 32'h41, r_data);
        cmd(4'h3, 32'h0, 32'h40, 32'h0);
        chk("and clr", 32'h40, r_data);
    endtask : mask_test
    // polled transfers, late error report, timeout
    task automatic rw_test;
        cmd(4'h1, 32'h10, 32'h12345678, 32'h0);
        chk("wr err", 1'h0, r_err);
        cmd(4'h0, 32'h10, 32'h0, 32'h0);
        chk("rd data", 32'h12345678, r_data);
        chk("am", 6'h0d, am);
        chk("lanes", 4'hf, lane);
        @(posedge ref_clk);
        shuf <= 1'h1;
        cmd(4'h0, 32'h10, 32'h0, 32'h0);
        chk("rd shuf", 32'h78563412, r_data);
        @(posedge ref_clk);
        shuf <= 1'h0;
        cmd(4'h1, 32'h80000000, 32'h0, 32'h0);
        chk("wr berr", 1'h0, r_err);
        cmd(4'h0, 32'h24, 32'h0, 32'h0);
        chk("late err", 1'h1, r_err);
        cmd(4'h0, 32'h24, 32'h0, 32'h0);
        chk("err gone", 1'h0, r_err);
        cmd(4'h0, 32'h40000000, 32'h0, 32'h0);
        chk("timeout", 1'h1, r_err);
    endtask : rw_test
    // compare-and-store hit then miss
    task automatic cas_test;
        cmd(4'h2, 32'h10, 32'hcafe0001, 32'h12345678);
        chk("cas hit", 1'h1, r_ok);
        chk("own", 1'h0, own);
        cmd(4'h2, 32'h10, 32'h1, 32'h12345678);
        chk("cas miss", 1'h0, r_ok);
        cmd(4'h0, 32'h10, 32'h0, 32'h0);
        chk("cas mem", 32'hcafe0001, r_data);
    endtask : cas_test
    // interrupter: level 3 with a status byte
    task automatic post_test;
        cmd(4'h7, 32'h3, 32'ha5, 32'h0);
        chk("post ok", 1'h1, r_ok);
        chk("post lvl", 7'h04, lvl);
        chk("post stat", 8'ha5, got);
    endtask : post_test
    // window mapping inside one mode context
    task automatic map(input logic [5:0] m, input u, input logic [31:0] ad,
                       input logic [31:0] ln);
        @(posedge ref_clk);
        {cmd_am, cmd_am_use} <= {m, u};
        cmd(4'h8, ad, 32'h0, ln);
    endtask : map
    task automatic map_test;
        @(posedge ref_clk);
        {cmd_am, cmd_am_use} <= {6'h29, 1'h1};
        cmd(4'h9, 32'h0, 32'h0, 32'h0);
        map(6'h0, 1'h0, 32'h1000, 32'h100);
        chk("map base", 32'hc0000000, r_data);
        map(6'h0, 1'h0, 32'h1080, 32'h10);
        chk("map in", 32'hc0000080, r_data);
        map(6'h0, 1'h0, 32'h2000, 32'h4);
        chk("map out", 1'h1, r_err);
        map(6'h0, 1'h0, 32'h1000, 32'h0);
        chk("map len", 1'h1, r_err);
        cmd(4'h9, 32'h0, 32'h0, 32'h0);
        chk("mode busy", 1'h1, r_err);
        map(6'h39, 1'h1, 32'h1000, 32'h4);
        chk("map am", 1'h1, r_err);
        map(6'h29, 1'h1, 32'h1000, 32'h4);
        chk("map kept", 1'h0, r_err);
        cmd(4'ha, 32'h0, 32'h0, 32'h0);
    endtask : map_test
    // counts, verdict, end of run
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    initial
    begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end
    // watchdog: whole run is under two thousand cycles
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        complete_run();
    end
    initial
    begin
        {rst, cmd_valid, cmd_am_use, int_seen} = 4'hf - 4'h7;
        {cmd_op, cmd_addr, cmd_data, cmd_aux} = '0;
        {cmd_am, int_level, int_status, shuf} = '0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'h0;
        mask_test();
        rw_test();
        cas_test();
        post_test();
        map_test();
        complete_run();
    end
endmodule : vme_host_bus_interface_tb
